/* src/temp_fifo_params.svh */
// offsets, field positions, reset values and counts for the sample fifo
`ifndef TEMP_FIFO_PARAMS_SVH
`define TEMP_FIFO_PARAMS_SVH

`define ADDR_STATUS        8'h00
`define ADDR_IRQ_ENABLE    8'h01
`define ADDR_PUSH_POINTER  8'h04
`define ADDR_POP_POINTER   8'h05
`define ADDR_LOST_COUNT    8'h06
`define ADDR_AVAIL_WORDS   8'h07
`define ADDR_READ_PORT     8'h08
`define ADDR_WATERMARK     8'h09
`define ADDR_POLICY        8'h0a
`define ADDR_PIN_SETUP     8'h20

`define BIT_STATUS_AFULL   7
`define BIT_STATUS_RDY     0
`define BIT_OVERWRITE      1
`define BIT_AFULL_ONESHOT  2
`define BIT_CLEAR_ON_POP   3
`define BIT_FLUSH          4

`define FIFO_DEPTH         6'h20
`define LOST_MAX           5'h1f
`define IRQ_FUNC_AFULL     2'h3
`define RESET_BYTE         8'h00

`endif

/* src/temp_fifo_pkg.sv */
// types shared by the sample fifo files
package temp_fifo_pkg;
  typedef logic [4:0]  ptr_t;
  typedef logic [15:0] sample_t;
  typedef enum logic {
    PH_HIGH = 1'b0,
    PH_LOW  = 1'b1
  } byte_phase_e;
endpackage

/* src/fifo_sample_store.sv */
// 32 x 16 sample storage with one write and one read port
`timescale 1ns/1ps
module fifo_sample_store (
  input  wire logic                  clk,
  input  wire logic                  wrEn,
  input  wire temp_fifo_pkg::ptr_t    wrAddr,
  input  wire temp_fifo_pkg::sample_t wrData,
  input  wire temp_fifo_pkg::ptr_t    rdAddr,
  output      temp_fifo_pkg::sample_t rdData
);
  temp_fifo_pkg::sample_t mem [0:31];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  assign rdData = mem[rdAddr];
endmodule

/* src/almost_full_flag.sv */
// sticky almost-full flag with level or fresh-entry setting
`timescale 1ns/1ps
module almost_full_flag (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic cond,
  input  wire logic pushed,
  input  wire logic oneShot,
  input  wire logic clear,
  output      logic flag
);
  logic condPrev_reg;
  logic condPrev_next;
  logic flag_reg;
  logic flag_next;
  logic setEvent;

  always_comb begin
    condPrev_next = cond;
    // fresh entry only, or every sample while held
    if (oneShot) begin
      setEvent = cond & ~condPrev_reg;
    end else begin
      setEvent = cond & pushed;
    end
    flag_next = flag_reg;
    if (clear) begin
      flag_next = 1'b0;
    end
    if (setEvent) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      condPrev_reg <= 1'b0;
      flag_reg     <= 1'b0;
    end else begin
      condPrev_reg <= condPrev_next;
      flag_reg     <= flag_next;
    end
  end

  assign flag = flag_reg;
endmodule

/* src/temperature_sample_fifo.sv */
// temperature sample fifo with its register window
`timescale 1ns/1ps
`include "temp_fifo_params.svh"

// Notes on behaviour
// - read-only six-bit count: up on push when not full, down on complete word read
// - read port is 8-bit read-only; two-byte burst advances pop pointer once
// - first byte carries bits 15..8, second byte bits 7..0
// - almost-full when stored words reach 32 minus the watermark
// - irq pin asserts on almost-full when enabled and pin function is 3
// - rollover on and full: new sample overwrites the oldest
// - rollover off and full: sample dropped, contents and pointer kept
// - level type: flag sets on every sample while condition holds
// - one-shot type: flag sets only on fresh entry into condition
// - clear-on-pop off: flags clear only on status read
// - clear-on-pop on: flags clear on data read or status read
// - flush zeroes pointers and counts, leaves stored contents, then self-clears
// - five-bit push pointer advances per written sample (not on a dropped one) and wraps to zero
// - five-bit pop pointer is host writable for rereads, wraps to zero
// - lost count rises per lost word, saturates, zeroes on a pop
// - address stays put while the read port is being read
module temperature_sample_fifo (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  pushValid,
  input  wire temp_fifo_pkg::sample_t pushData,
  input  wire logic                  linkClk,
  input  wire logic                  burstStart,
  input  wire logic [7:0]            regAddr,
  input  wire logic                  regRdEn,
  input  wire logic                  regWrEn,
  input  wire logic [7:0]            regWrData,
  output      logic [7:0]            regRdData,
  output      logic                  holdAddr,
  output      logic                  irqOutputPin
);
  ////////////////////////////////////////////////////////////////////////////
  // link clock sampling
  logic sclMeta_reg;
  logic sclSync_reg;
  logic sclPrev_reg;
  logic sclFall;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclMeta_reg <= 1'b1;
      sclSync_reg <= 1'b1;
      sclPrev_reg <= 1'b1;
    end else begin
      sclMeta_reg <= linkClk;
      sclSync_reg <= sclMeta_reg;
      sclPrev_reg <= sclSync_reg;
    end
  end

  assign sclFall = sclPrev_reg & ~sclSync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  logic rdTake;
  logic dataRd;
  logic statusRd;
  logic popTake;
  logic ptrWr;
  logic flushReq;
  temp_fifo_pkg::byte_phase_e phase_reg;
  temp_fifo_pkg::byte_phase_e phase_next;

  // a read is taken on the link's falling edge so its byte is ready to shift
  assign rdTake   = regRdEn & sclFall;
  assign dataRd   = rdTake & (regAddr == `ADDR_READ_PORT);
  assign statusRd = rdTake & (regAddr == `ADDR_STATUS);
  assign popTake  = dataRd & (phase_reg == temp_fifo_pkg::PH_LOW);
  assign ptrWr    = regWrEn & (regAddr == `ADDR_POP_POINTER);
  assign flushReq = regWrEn & (regAddr == `ADDR_POLICY)
                    & regWrData[`BIT_FLUSH];

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [4:0] watermark_reg;
  logic [4:0] watermark_next;
  logic [2:0] policy_reg;
  logic [2:0] policy_next;
  logic [1:0] irqEnable_reg;
  logic [1:0] irqEnable_next;
  logic [1:0] pinFunc_reg;
  logic [1:0] pinFunc_next;
  logic       overwriteWhenFull;
  logic       aFullOneShot;
  logic       clearFlagsOnPop;

  always_comb begin
    watermark_next = watermark_reg;
    policy_next    = policy_reg;
    irqEnable_next = irqEnable_reg;
    pinFunc_next   = pinFunc_reg;
    if (regWrEn) begin
      unique case (regAddr)
        `ADDR_WATERMARK: begin
          watermark_next = regWrData[4:0];
        end
        `ADDR_POLICY: begin
          // flush bit is not stored, so it reads back as zero
          policy_next = regWrData[3:1];
        end
        `ADDR_IRQ_ENABLE: begin
          irqEnable_next = {regWrData[7], regWrData[0]};
        end
        `ADDR_PIN_SETUP: begin
          pinFunc_next = regWrData[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      watermark_reg <= 5'h00;
      policy_reg    <= 3'h0;
      irqEnable_reg <= 2'h0;
      pinFunc_reg   <= 2'h0;
    end else begin
      watermark_reg <= watermark_next;
      policy_reg    <= policy_next;
      irqEnable_reg <= irqEnable_next;
      pinFunc_reg   <= pinFunc_next;
    end
  end

  assign overwriteWhenFull = policy_reg[0];
  assign aFullOneShot      = policy_reg[1];
  assign clearFlagsOnPop   = policy_reg[2];

  ////////////////////////////////////////////////////////////////////////////
  // pointers and counters
  temp_fifo_pkg::ptr_t pushPointer_reg;
  temp_fifo_pkg::ptr_t pushPointer_next;
  temp_fifo_pkg::ptr_t popPointer_reg;
  temp_fifo_pkg::ptr_t popPointer_next;
  logic [5:0]          avail_reg;
  logic [5:0]          avail_next;
  logic [4:0]          lostWordCount_reg;
  logic [4:0]          lostWordCount_next;
  logic                memWr;
  logic                fullAfterPop;

  always_comb begin
    pushPointer_next   = pushPointer_reg;
    popPointer_next    = popPointer_reg;
    avail_next         = avail_reg;
    lostWordCount_next = lostWordCount_reg;
    memWr              = 1'b0;
    fullAfterPop       = 1'b0;
    if (flushReq) begin
      pushPointer_next   = 5'h00;
      popPointer_next    = 5'h00;
      avail_next         = 6'h00;
      lostWordCount_next = 5'h00;
    end else begin
      if (popTake) begin
        popPointer_next    = popPointer_reg + 5'h01;
        lostWordCount_next = 5'h00;
        if (avail_reg != 6'h00) begin
          avail_next = avail_reg - 6'h01;
        end
      end
      fullAfterPop = (avail_next == `FIFO_DEPTH);
      if (pushValid) begin
        if (!fullAfterPop) begin
          memWr            = 1'b1;
          pushPointer_next = pushPointer_reg + 5'h01;
          avail_next       = avail_next + 6'h01;
        end else if (overwriteWhenFull) begin
          memWr            = 1'b1;
          pushPointer_next = pushPointer_reg + 5'h01;
          popPointer_next  = popPointer_next + 5'h01;
        end
        if (fullAfterPop && lostWordCount_next != `LOST_MAX) begin
          lostWordCount_next = lostWordCount_next + 5'h01;
        end
      end
      if (ptrWr) begin
        popPointer_next = regWrData[4:0];
        avail_next      = {1'b0, pushPointer_next - regWrData[4:0]};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pushPointer_reg   <= 5'h00;
      popPointer_reg    <= 5'h00;
      avail_reg         <= 6'h00;
      lostWordCount_reg <= 5'h00;
    end else begin
      pushPointer_reg   <= pushPointer_next;
      popPointer_reg    <= popPointer_next;
      avail_reg         <= avail_next;
      lostWordCount_reg <= lostWordCount_next;
    end
  end

  temp_fifo_pkg::sample_t headWord;

  fifo_sample_store store (
    .clk    (clk),
    .wrEn   (memWr),
    .wrAddr (pushPointer_reg),
    .wrData (pushData),
    .rdAddr (popPointer_reg),
    .rdData (headWord)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status flags
  logic pushSeen_reg;
  logic pushSeen_next;
  logic sampleReady_reg;
  logic sampleReady_next;
  logic flagClear;
  logic aFullCond;
  logic aFullFlag;

  // status read always clears; data read clears only when chosen
  assign flagClear = statusRd | (dataRd & clearFlagsOnPop);
  assign aFullCond = avail_reg >= (`FIFO_DEPTH - {1'b0, watermark_reg});

  always_comb begin
    pushSeen_next    = pushValid;
    sampleReady_next = sampleReady_reg;
    if (flagClear) begin
      sampleReady_next = 1'b0;
    end
    if (pushValid) begin
      sampleReady_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pushSeen_reg    <= 1'b0;
      sampleReady_reg <= 1'b0;
    end else begin
      pushSeen_reg    <= pushSeen_next;
      sampleReady_reg <= sampleReady_next;
    end
  end

  almost_full_flag afull (
    .clk     (clk),
    .rst     (rst),
    .cond    (aFullCond),
    .pushed  (pushSeen_reg),
    .oneShot (aFullOneShot),
    .clear   (flagClear),
    .flag    (aFullFlag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data, byte phase and outputs
  logic [7:0] rdMux;
  logic [7:0] regRdData_reg;
  logic [7:0] regRdData_next;
  logic       holdAddr_reg;
  logic       holdAddr_next;
  logic       irq_reg;
  logic       irq_next;

  always_comb begin
    unique case (regAddr)
      `ADDR_STATUS:       rdMux = {aFullFlag, 6'h00, sampleReady_reg};
      `ADDR_IRQ_ENABLE:   rdMux = {irqEnable_reg[1], 6'h00, irqEnable_reg[0]};
      `ADDR_PUSH_POINTER: rdMux = {3'h0, pushPointer_reg};
      `ADDR_POP_POINTER:  rdMux = {3'h0, popPointer_reg};
      `ADDR_LOST_COUNT:   rdMux = {3'h0, lostWordCount_reg};
      `ADDR_AVAIL_WORDS:  rdMux = {2'h0, avail_reg};
      `ADDR_READ_PORT: begin
        if (phase_reg == temp_fifo_pkg::PH_HIGH) begin
          rdMux = headWord[15:8];
        end else begin
          rdMux = headWord[7:0];
        end
      end
      `ADDR_WATERMARK:    rdMux = {3'h0, watermark_reg};
      `ADDR_POLICY:       rdMux = {3'h0, 1'b0, policy_reg, 1'b0};
      `ADDR_PIN_SETUP:    rdMux = {6'h00, pinFunc_reg};
      default:            rdMux = `RESET_BYTE;
    endcase
  end

  always_comb begin
    phase_next     = phase_reg;
    regRdData_next = regRdData_reg;
    if (rdTake) begin
      regRdData_next = rdMux;
    end
    if (burstStart || flushReq || ptrWr) begin
      phase_next = temp_fifo_pkg::PH_HIGH;
    end else if (dataRd) begin
      if (phase_reg == temp_fifo_pkg::PH_HIGH) begin
        phase_next = temp_fifo_pkg::PH_LOW;
      end else begin
        phase_next = temp_fifo_pkg::PH_HIGH;
      end
    end
    holdAddr_next = (regAddr == `ADDR_READ_PORT);
    irq_next      = aFullFlag & irqEnable_reg[1]
                    & (pinFunc_reg == `IRQ_FUNC_AFULL);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg     <= temp_fifo_pkg::PH_HIGH;
      regRdData_reg <= `RESET_BYTE;
      holdAddr_reg  <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      phase_reg     <= phase_next;
      regRdData_reg <= regRdData_next;
      holdAddr_reg  <= holdAddr_next;
      irq_reg       <= irq_next;
    end
  end

  assign regRdData    = regRdData_reg;
  assign holdAddr     = holdAddr_reg;
  assign irqOutputPin = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic quiet;
  assign quiet = ~flushReq & ~ptrWr;

  chk_count_bound: assert property (avail_reg <= `FIFO_DEPTH)
    else $error("available count above depth");
  chk_count_push: assert property (
    pushValid && !fullAfterPop && !popTake && quiet
    |=> avail_reg == $past(avail_reg) + 6'h01)
    else $error("count did not rise on push");
  chk_pop_advance: assert property (popTake && quiet && !pushValid
    |=> popPointer_reg == $past(popPointer_reg) + 5'h01)
    else $error("pop pointer did not advance once");
  chk_first_byte: assert property (
    dataRd && phase_reg == temp_fifo_pkg::PH_HIGH
    |=> regRdData == $past(headWord[15:8]))
    else $error("first byte is not the high half");
  chk_discard_hold: assert property (
    pushValid && fullAfterPop && !overwriteWhenFull && !popTake && quiet
    |=> pushPointer_reg == $past(pushPointer_reg))
    else $error("discarded sample moved push pointer");
  chk_rollover_full: assert property (
    pushValid && fullAfterPop && overwriteWhenFull && !popTake && quiet
    |=> avail_reg == `FIFO_DEPTH
        && popPointer_reg == $past(popPointer_reg) + 5'h01)
    else $error("rollover did not overwrite oldest");
  chk_flush_zero: assert property (flushReq |=> pushPointer_reg == 5'h00
    && popPointer_reg == 5'h00 && avail_reg == 6'h00
    && lostWordCount_reg == 5'h00)
    else $error("flush left state behind");
  chk_lost_sat: assert property (
    lostWordCount_reg == `LOST_MAX && !popTake && !flushReq
    |=> lostWordCount_reg == `LOST_MAX)
    else $error("lost count left saturation");
  chk_afull_level: assert property (
    aFullCond && pushSeen_reg && !aFullOneShot
    |=> aFullFlag)
    else $error("level flag not set on sample");
  chk_irq_gate: assert property (irqOutputPin
    |-> $past(aFullFlag) && $past(irqEnable_reg[1]))
    else $error("irq without enabled flag");
  chk_clear_keep: assert property (
    dataRd && !clearFlagsOnPop && !statusRd && !pushValid && sampleReady_reg
    |=> sampleReady_reg)
    else $error("data read cleared flags");

  cov_overwrite: cover property (pushValid && fullAfterPop
    && overwriteWhenFull);
  cov_burst_pop: cover property (dataRd ##[1:40] popTake);
  cov_flush: cover property (flushReq && avail_reg != 6'h00);
  cov_irq: cover property ($rose(irqOutputPin));
endmodule

/* test/serial_host_model.sv */
// host model: reads and writes fifo registers over the serial engine
`timescale 1ns/1ps
`include "temp_fifo_params.svh"
module serial_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] regRdData,
  output      logic       linkClk,
  output      logic       burstStart,
  output      logic [7:0] regAddr,
  output      logic       regRdEn,
  output      logic       regWrEn,
  output      logic [7:0] regWrData
);
  initial begin
    linkClk = 1'b1;
    burstStart = 1'b0;
    regAddr = 8'h00;
    regRdEn = 1'b0;
    regWrEn = 1'b0;
    regWrData = 8'h00;
  end
  ////////////////////////////////////////
  // one byte per link clock fall; link idles high between bytes
  task automatic readByte(input logic [7:0] a, output logic [7:0] d);
    regAddr = a;
    regRdEn = 1'b1;
    linkClk = 1'b0;
    // low half of an 800 ns link period; the byte is taken on the third edge
    repeat (4) @(negedge clk);
    d = regRdData;
    linkClk = 1'b1;
    regRdEn = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
    regWrData = ~d;
    @(negedge clk);
  endtask

  // each sample fetched as a two-byte burst
  task automatic readWord(output logic [15:0] w);
    logic [7:0] hi;
    logic [7:0] lo;
    burstStart = 1'b1;
    @(negedge clk);
    burstStart = 1'b0;
    readByte(`ADDR_READ_PORT, hi);
    readByte(`ADDR_READ_PORT, lo);
    w = {hi, lo};
  endtask

  // lost count first, then available count
  task automatic availableWords(output logic [7:0] n);
    logic [7:0] lc;
    readByte(`ADDR_LOST_COUNT, lc);
    readByte(`ADDR_AVAIL_WORDS, n);
    if (lc !== 8'h00) begin
      n = 8'h20;
    end
  endtask

  // span between pointers when nothing was lost
  task automatic pointerSpan(output logic [7:0] n);
    logic [7:0] lc;
    logic [7:0] wp;
    logic [7:0] rp;
    readByte(`ADDR_LOST_COUNT, lc);
    readByte(`ADDR_PUSH_POINTER, wp);
    readByte(`ADDR_POP_POINTER, rp);
    n = (lc !== 8'h00) ? 8'h20 : {3'h0, wp[4:0] - rp[4:0]};
  endtask
endmodule

/* test/temperature_sample_fifo_test.sv */
// self-checking bench for the temperature sample fifo
`timescale 1ns/1ps
`include "temp_fifo_params.svh"
module temperature_sample_fifo_test;
  logic                   clk;
  logic                   rst;
  logic                   pushValid;
  temp_fifo_pkg::sample_t pushData;
  logic                   linkClk;
  logic                   burstStart;
  logic [7:0]             regAddr;
  logic                   regRdEn;
  logic                   regWrEn;
  logic [7:0]             regWrData;
  logic [7:0]             regRdData;
  logic                   holdAddr;
  logic                   irqOutputPin;
  int                     failures;
  int                     checked;
  temp_fifo_pkg::sample_t mem [32];
  temp_fifo_pkg::ptr_t    wp;
  temp_fifo_pkg::ptr_t    rp;
  int                     cnt;
  int                     lost;
  int                     w;
  logic                   roll;
  logic [7:0]             b;
  logic [7:0]             ra [8];

  temperature_sample_fifo dut (
    .clk, .rst, .pushValid, .pushData, .linkClk, .burstStart, .regAddr,
    .regRdEn, .regWrEn, .regWrData, .regRdData, .holdAddr, .irqOutputPin
  );
  serial_host_model host (
    .clk, .regRdData, .linkClk, .burstStart, .regAddr, .regRdEn,
    .regWrEn, .regWrData
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #3000000;
    failures++;
    test_done();
  end
  ////////////////////////////////////////
  task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic checkBit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic push(input int n);
    repeat (n) begin
      pushData = temp_fifo_pkg::sample_t'($urandom);
      pushValid = 1'b1;
      if (cnt < 32 || roll) begin
        mem[wp] = pushData;
        wp++;
      end
      if (cnt == 32) begin
        lost = (lost < 31) ? lost + 1 : 31;
        if (roll) begin
          rp++;
        end
      end else begin
        cnt++;
      end
      @(negedge clk);
    end
    pushValid = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic popWord();
    logic [15:0] word;
    host.readWord(word);
    checkVal(word, mem[rp]);
    checkBit(holdAddr, 1'b1);
    rp++;
    cnt--;
    lost = 0;
  endtask

  task automatic checkState();
    host.readByte(`ADDR_PUSH_POINTER, b);
    checkVal(16'(b), 16'(wp));
    host.readByte(`ADDR_POP_POINTER, b);
    checkVal(16'(b), 16'(rp));
    host.readByte(`ADDR_LOST_COUNT, b);
    checkVal(16'(b), 16'(lost));
    host.readByte(`ADDR_AVAIL_WORDS, b);
    checkVal(16'(b), 16'(cnt));
    checkBit(holdAddr, 1'b0);
  endtask

  task automatic status(input logic [7:0] exp);
    host.readByte(`ADDR_STATUS, b);
    checkVal(16'(b), 16'(exp));
  endtask

  task automatic flush();
    host.writeReg(`ADDR_POLICY, 8'h10);
    wp = 5'h00;
    rp = 5'h00;
    cnt = 0;
    lost = 0;
  endtask
  ////////////////////////////////////////
  initial begin
    failures = 0;
    checked = 0;
    rst = 1'b1;
    pushValid = 1'b0;
    pushData = 16'h0000;
    wp = 5'h00;
    rp = 5'h00;
    cnt = 0;
    lost = 0;
    roll = 1'b0;
    ra = '{8'h00, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0a};
    void'($urandom(32'hda0371cf));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    // reset values and an unmapped address
    foreach (ra[i]) begin
      host.readByte(ra[i], b);
      checkVal(16'(b), 16'h0000);
    end
    // pushes, pops, read-only write, reread
    push($urandom_range(3, 9));
    host.writeReg(`ADDR_PUSH_POINTER, 8'h1f);
    checkState();
    popWord();
    popWord();
    checkState();
    host.pointerSpan(b);
    checkVal(16'(b), 16'(cnt));
    host.writeReg(`ADDR_POP_POINTER, 8'h00);
    rp = 5'h00;
    cnt = int'(wp);
    popWord();
    checkState();
    // watermark, level and one-shot flag, interrupt pin
    flush();
    w = $urandom_range(2, 6);
    host.writeReg(`ADDR_WATERMARK, 8'(w));
    host.writeReg(`ADDR_IRQ_ENABLE, 8'h80);
    host.writeReg(`ADDR_PIN_SETUP, 8'h03);
    push(31 - w);
    status(8'h01);
    checkBit(irqOutputPin, 1'b0);
    push(1);
    checkBit(irqOutputPin, 1'b1);
    status(8'h81);
    checkBit(irqOutputPin, 1'b0);
    status(8'h00);
    push(1);
    status(8'h81);
    host.writeReg(`ADDR_POLICY, 8'h04);
    push(1);
    status(8'h01);
    // full with discard, lost count saturates
    host.writeReg(`ADDR_POLICY, 8'h00);
    push(65 - cnt);
    checkState();
    popWord();
    checkState();
    // full with rollover
    host.writeReg(`ADDR_POLICY, 8'h02);
    roll = 1'b1;
    push(4);
    checkState();
    host.availableWords(b);
    checkVal(16'(b), 16'h0020);
    popWord();
    roll = 1'b0;
    // flush, then flag clearing by data reads
    flush();
    host.readByte(`ADDR_POLICY, b);
    checkVal(16'(b), 16'h0000);
    checkState();
    host.readByte(`ADDR_STATUS, b);
    push(1);
    popWord();
    status(8'h01);
    status(8'h00);
    host.writeReg(`ADDR_POLICY, 8'h08);
    push(1);
    popWord();
    status(8'h00);
    test_done();
  end
endmodule
